// ---- rtl/codec_node_addr.sv ----
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module codec_node_addr #(
    parameter int LIST_DEPTH = 128
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic link_clk_i,
    input wire logic link_sync_i,
    input wire logic link_sdo_i,
    output logic cmd_valid_o,
    output codec_node_pkg::node_class_t cmd_class_o,
    output logic [codec_node_pkg::NID_W-1:0] cmd_nid_o,
    output logic [codec_node_pkg::PAY_MSB:0] cmd_payload_o,
    output logic rsp_valid_o,
    output logic [31:0] rsp_data_o,
    output logic [codec_node_pkg::LNID_W-1:0] sel_node_o,
    output logic route_l_o,
    output logic route_r_o,
    output logic mix_dual_o
);
    import codec_node_pkg::*;

    function automatic logic in_range(input logic [15:0] n, input logic [7:0] st,
                                      input logic [7:0] cnt);
        in_range = (n >= {8'h00, st}) && (n < ({8'h00, st} + {8'h00, cnt}));
    endfunction

    // ==========================================
    // Link input synchronisers
    logic ck_s1, ck_s2, ck_s3, sy_s1, sy_s2, do_s1, do_s2;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            {ck_s1, ck_s2, ck_s3} <= 3'h0;
            {sy_s1, sy_s2, do_s1, do_s2} <= 4'h0;
        end else begin
            ck_s1 <= link_clk_i;
            ck_s2 <= ck_s1;
            ck_s3 <= ck_s2;
            sy_s1 <= link_sync_i;
            sy_s2 <= sy_s1;
            do_s1 <= link_sdo_i;
            do_s2 <= do_s1;
        end
    end
    logic rise;
    assign rise = ck_s2 & ~ck_s3;

    // ==========================================
    // Command word assembly, MSB first after sync
    logic [5:0] bit_cnt_reg;
    logic [30:0] shift_reg;
    logic [31:0] word_reg;
    logic hit_reg;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            bit_cnt_reg <= 6'h00;
            shift_reg <= 31'h0;
            word_reg <= 32'h0;
            hit_reg <= 1'b0;
        end else begin
            hit_reg <= 1'b0;
            if (rise && sy_s2) begin
                bit_cnt_reg <= 6'h01;
                shift_reg <= {30'h0, do_s2};
            end else if (rise && bit_cnt_reg != 6'h00) begin
                shift_reg <= {shift_reg[29:0], do_s2};
                if (bit_cnt_reg == 6'h1f) begin
                    word_reg <= {shift_reg, do_s2};
                    hit_reg <= 1'b1;
                    bit_cnt_reg <= 6'h00;
                end else begin
                    bit_cnt_reg <= bit_cnt_reg + 6'h01;
                end
            end
        end
    end

    // ==========================================
    // Registers
    logic [4:0] ctrl_reg;
    logic [31:0] topo_reg;
    logic [10:0] wcfg_reg;
    logic [6:0] sel_reg, ptr_reg;
    logic prev_rng_reg, list_err_reg, foreign_reg, ind_seen_reg;
    logic pready_reg, pslverr_reg;
    logic [31:0] prdata_reg;
    logic fire, wr;
    assign fire = psel_i & penable_i & pready_reg;
    assign wr = fire & pwrite_i;

    logic [3:0] my_cad;
    logic [7:0] fg_start, fg_cnt, w_start, w_cnt;
    logic [6:0] list_len;
    logic long_form, sink_st, sink_mix, src_st;
    assign my_cad = ctrl_reg[3:0];
    assign fg_start = topo_reg[7:0];
    assign fg_cnt = topo_reg[15:8];
    assign w_start = topo_reg[23:16];
    assign w_cnt = topo_reg[31:24];
    assign list_len = wcfg_reg[6:0];
    assign long_form = wcfg_reg[WCFG_LONG];
    assign sink_st = wcfg_reg[WCFG_STEREO];
    assign sink_mix = wcfg_reg[WCFG_MIXER];
    assign src_st = wcfg_reg[WCFG_SRCST];

    // Configuration registers
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ctrl_reg <= CTRL_RST;
            topo_reg <= TOPO_RST;
            wcfg_reg <= WCFG_RST;
        end else if (wr) begin
            if (paddr_i == CTRL_OFF) ctrl_reg <= pwdata_i[4:0];
            if (paddr_i == TOPO_OFF) begin
                topo_reg <= pwdata_i;
                if (pwdata_i[15:8] == 8'h00) topo_reg[15:8] <= 8'h01;
            end
            if (paddr_i == WCFG_OFF) wcfg_reg <= pwdata_i[10:0];
        end
    end

    // Source select, absent when the input is hard-wired
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sel_reg <= 7'h00;
        end else if (list_len <= 7'h01) begin
            sel_reg <= 7'h00;
        end else if (wr && paddr_i == SEL_OFF && pwdata_i[6:0] < list_len) begin
            sel_reg <= pwdata_i[6:0];
        end
    end

    // List pointer and entry checks
    logic lwr, ent_rng;
    logic [15:0] ent_nid;
    assign lwr = wr && paddr_i == LDATA_OFF;
    assign ent_rng = long_form ? pwdata_i[15] : pwdata_i[7];
    assign ent_nid = long_form ? {1'b0, pwdata_i[14:0]} : {9'h000, pwdata_i[6:0]};
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ptr_reg <= 7'h00;
            prev_rng_reg <= 1'b0;
        end else if (wr && paddr_i == PTR_OFF) begin
            ptr_reg <= pwdata_i[6:0];
            prev_rng_reg <= 1'b0;
        end else if (lwr) begin
            ptr_reg <= ptr_reg + 7'h01;
            prev_rng_reg <= ent_rng;
        end
    end

    // Sticky error flags, set wins over write-one clear
    logic clr;
    assign clr = wr && paddr_i == STAT_OFF;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            list_err_reg <= 1'b0;
            foreign_reg <= 1'b0;
        end else begin
            if (lwr && ent_rng && (ptr_reg == 7'h00 || prev_rng_reg)) begin
                list_err_reg <= 1'b1;
            end else if (clr && pwdata_i[ST_LISTERR]) begin
                list_err_reg <= 1'b0;
            end
            if (lwr && !in_range(ent_nid, w_start, w_cnt)) begin
                foreign_reg <= 1'b1;
            end else if (clr && pwdata_i[ST_FOREIGN]) begin
                foreign_reg <= 1'b0;
            end
        end
    end

    // ==========================================
    // Source list memory
    logic [15:0] rd_a, rd_b;
    conn_list_mem #(.DEPTH(LIST_DEPTH), .WIDTH(16), .AW(7)) u_mem (
        .clk_i(core_clk_i),
        .we_i(lwr),
        .waddr_i(ptr_reg),
        .wdata_i(pwdata_i[15:0]),
        .raddr_a_i(ptr_reg),
        .rdata_a_o(rd_a),
        .raddr_b_i(sel_reg),
        .rdata_b_o(rd_b)
    );

    // Selected source node
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sel_node_o <= 15'h0000;
        end else begin
            sel_node_o <= long_form ? rd_b[14:0] : {8'h00, rd_b[6:0]};
        end
    end

    // ==========================================
    // Channel routing, 0 picks source left, 1 source right
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            route_l_o <= 1'b0;
            route_r_o <= 1'b0;
            mix_dual_o <= 1'b0;
        end else begin
            route_l_o <= 1'b0;
            if (sink_st) begin
                route_r_o <= src_st;
                mix_dual_o <= 1'b0;
            end else if (sink_mix && list_len == 7'h01 && src_st) begin
                route_r_o <= 1'b1;
                mix_dual_o <= 1'b1;
            end else begin
                route_r_o <= 1'b0;
                mix_dual_o <= 1'b0;
            end
        end
    end

    // ==========================================
    // Command decode and answer
    logic [3:0] w_cad;
    logic [6:0] w_nid;
    logic w_ind, cad_ok;
    node_class_t w_cls;
    assign w_cad = word_reg[CAD_MSB:CAD_LSB];
    assign w_ind = word_reg[IND_BIT];
    assign w_nid = word_reg[NID_MSB:NID_LSB];
    assign cad_ok = ctrl_reg[4] && (w_cad == my_cad || w_cad == BCAST_CAD);
    always_comb begin
        if (w_nid == 7'h00) begin
            w_cls = NODE_ROOT;
        end else if (in_range({9'h000, w_nid}, fg_start, fg_cnt)) begin
            w_cls = NODE_FG;
        end else if (in_range({9'h000, w_nid}, w_start, w_cnt)) begin
            w_cls = NODE_WIDGET;
        end else begin
            w_cls = NODE_NONE;
        end
    end

    // Accepted command fields and parameter answer
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cmd_valid_o <= 1'b0;
            cmd_class_o <= NODE_NONE;
            cmd_nid_o <= 7'h00;
            cmd_payload_o <= 20'h00000;
            rsp_valid_o <= 1'b0;
            rsp_data_o <= 32'h0;
        end else begin
            cmd_valid_o <= 1'b0;
            rsp_valid_o <= 1'b0;
            if (hit_reg && cad_ok && !w_ind && w_cls != NODE_NONE) begin
                cmd_valid_o <= 1'b1;
                rsp_valid_o <= 1'b1;
                cmd_class_o <= w_cls;
                cmd_nid_o <= w_nid;
                cmd_payload_o <= word_reg[PAY_MSB:0];
                unique case (w_cls)
                    NODE_ROOT: rsp_data_o <= {8'h00, fg_start, 8'h00, fg_cnt};
                    NODE_FG: rsp_data_o <= {8'h00, w_start, 8'h00, w_cnt};
                    NODE_WIDGET: rsp_data_o <= {21'h0, wcfg_reg};
                    NODE_NONE: rsp_data_o <= 32'h0;
                endcase
            end
        end
    end

    // Indirect addressing seen, not served
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ind_seen_reg <= 1'b0;
        end else if (hit_reg && cad_ok && w_ind) begin
            ind_seen_reg <= 1'b1;
        end else if (clr && pwdata_i[ST_INDSEEN]) begin
            ind_seen_reg <= 1'b0;
        end
    end

    // ==========================================
    // APB slave, one wait state
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end else begin
            pready_reg <= psel_i & penable_i & ~pready_reg;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
            if (psel_i && penable_i && !pready_reg) begin
                unique case (paddr_i)
                    CTRL_OFF: prdata_reg <= {27'h0, ctrl_reg};
                    TOPO_OFF: prdata_reg <= topo_reg;
                    WCFG_OFF: prdata_reg <= {21'h0, wcfg_reg};
                    SEL_OFF: prdata_reg <= {25'h0, sel_reg};
                    PTR_OFF: prdata_reg <= {25'h0, ptr_reg};
                    LDATA_OFF: prdata_reg <= {16'h0, rd_a};
                    STAT_OFF: prdata_reg <= {21'h0, ind_seen_reg, foreign_reg,
                                             list_err_reg, 1'b0, cmd_nid_o};
                    ROUTE_OFF: prdata_reg <= {29'h0, mix_dual_o, route_r_o, route_l_o};
                    default: pslverr_reg <= 1'b1;
                endcase
            end
        end
    end
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign prdata_o = prdata_reg;

    // ==========================================
    // Assertions
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    bcast_accept_a: assert property (hit_reg && ctrl_reg[4] && w_cad == 4'hf && !w_ind &&
        w_cls != NODE_NONE |=> cmd_valid_o && rsp_valid_o)
        else $error("broadcast command not accepted");
    foreign_cad_a: assert property (hit_reg && w_cad != my_cad && w_cad != 4'hf
        |=> !cmd_valid_o && !rsp_valid_o)
        else $error("foreign address answered");
    root_node_a: assert property (cmd_valid_o && cmd_nid_o == 7'h00
        |-> cmd_class_o == NODE_ROOT && rsp_data_o[7:0] == $past(fg_cnt))
        else $error("root node answer wrong");
    nid_field_a: assert property (cmd_valid_o |-> cmd_nid_o == $past(word_reg[26:20])
        && cmd_payload_o == $past(word_reg[19:0]))
        else $error("node id field wrong");
    range_first_a: assert property (lwr && ent_rng && ptr_reg == 7'h00
        |=> list_err_reg)
        else $error("range flag in first entry missed");
    foreign_entry_a: assert property (lwr && !in_range(ent_nid, w_start, w_cnt)
        |=> foreign_reg)
        else $error("foreign widget entry missed");
    hard_wired_a: assert property (list_len == 7'h01 ##1 list_len == 7'h01
        |-> sel_reg == 7'h00)
        else $error("select present on fixed input");
    mono_stereo_a: assert property (sink_st && !src_st |=> !route_l_o && !route_r_o)
        else $error("mono source not on both channels");
    mono_mixer_a: assert property (!sink_st && sink_mix && src_st && list_len == 7'h01
        |=> mix_dual_o && route_r_o && !route_l_o)
        else $error("mono mixer inputs wrong");
endmodule // codec_node_addr
`default_nettype wire

// ---- rtl/codec_node_pkg.sv ----
// Function
// - Command bits 31:28 carry the codec link address.
// - Command bits 26:20 carry the seven-bit node identifier.
// - Bit 27 is kept for indirect addressing of long node identifiers.
// - Low command bits carry command code and payload.
// - Accept the broadcast address fifteen and the assigned address.
// - Root node answers at node identifier zero.
// - Root reports function group count and first group identifier.
// - At least one function group, numbered consecutively from that start.
// - Function group reports widget start; widgets numbered consecutively.
// - Node identifiers are seven bits, or fifteen in long form.
// - Source list count: low seven bits entries, top bit long form.
// - Entry top bit set means range with the entry before.
// - Range flag never in first entry nor two entries in a row.
// - Writable source select picks the feeding list entry.
// - Count of one means hard-wired input, no select field.
// - Each widget reports stereo or mono.
// - Stereo into stereo: left to left, right to right.
// - Mono into stereo drives both sink channels.
// - Stereo into mono: left only, except the mono mixer case.
// - Mono mixer with one stereo source gets left then right inputs.
// - Source lists never name widgets of another function group.
// - Paths between function groups are reported as external connections.
// - Vendor commands keep address fields and use bits 19:0.
package codec_node_pkg;
    // ==========================================
    // Command word layout
    localparam int CAD_MSB = 31;
    localparam int CAD_LSB = 28;
    localparam int IND_BIT = 27;
    localparam int NID_MSB = 26;
    localparam int NID_LSB = 20;
    localparam int PAY_MSB = 19;
    localparam int CMD_W = 32;
    localparam int NID_W = 7;
    localparam int LNID_W = 15;
    localparam logic [3:0] BCAST_CAD = 4'hf;
    // ==========================================
    // Register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] TOPO_OFF = 8'h04;
    localparam logic [7:0] WCFG_OFF = 8'h08;
    localparam logic [7:0] SEL_OFF = 8'h0c;
    localparam logic [7:0] PTR_OFF = 8'h10;
    localparam logic [7:0] LDATA_OFF = 8'h14;
    localparam logic [7:0] STAT_OFF = 8'h18;
    localparam logic [7:0] ROUTE_OFF = 8'h1c;
    // ==========================================
    // Field positions and reset values
    localparam int WCFG_LONG = 7;
    localparam int WCFG_STEREO = 8;
    localparam int WCFG_MIXER = 9;
    localparam int WCFG_SRCST = 10;
    localparam int ST_LISTERR = 8;
    localparam int ST_FOREIGN = 9;
    localparam int ST_INDSEEN = 10;
    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam logic [31:0] TOPO_RST = 32'h0202_0101;
    localparam logic [10:0] WCFG_RST = 11'h000;
    typedef enum logic [1:0] {NODE_NONE, NODE_ROOT, NODE_FG, NODE_WIDGET} node_class_t;
endpackage

// ---- rtl/conn_list_mem.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Source list storage, one write and two read ports
module conn_list_mem #(
    parameter int DEPTH = 128,
    parameter int WIDTH = 16,
    parameter int AW = 7
) (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_a_i,
    output logic [WIDTH-1:0] rdata_a_o,
    input wire logic [AW-1:0] raddr_b_i,
    output logic [WIDTH-1:0] rdata_b_o
);
    logic [WIDTH-1:0] mem [DEPTH];

    // Write port
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    // Registered reads
    always_ff @(posedge clk_i) begin
        rdata_a_o <= mem[raddr_a_i];
        rdata_b_o <= mem[raddr_b_i];
    end
endmodule // conn_list_mem
`default_nettype wire

// ---- sim/link_ctl_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Link controller model that sends command words
module link_ctl_model (
    output logic link_clk_o,
    output logic link_sync_o,
    output logic link_sdo_o
);
    // Idle link: clock low and still
    initial begin
        link_clk_o = 1'b0;
        link_sync_o = 1'b0;
        link_sdo_o = 1'b0;
    end

    // One frame, MSB first; data moves while the clock is low
    task automatic send(input logic [31:0] word);
        #7;
        for (int i = 31; i >= 0; i--) begin
            link_sdo_o = word[i];
            link_sync_o = (i == 31);
            #160 link_clk_o = 1'b1;
            #160 link_clk_o = 1'b0;
        end
        link_sync_o = 1'b0;
        link_sdo_o = ~word[0]; // Line left stale would hide sampling slips
    endtask
endmodule // link_ctl_model
`default_nettype wire

// ---- sim/codec_node_addr_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Bench for the node addressing block
module codec_node_addr_tb;
    import codec_node_pkg::*;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, rsp, cap_rsp, cap_id;
    logic lclk, lsync, lsdo, cmd_valid, rsp_valid, rl, rr, mix;
    node_class_t cls;
    logic [6:0] node_identifier;
    logic [19:0] pay, cap_pay;
    logic [14:0] sel_node;
    int n_errors, num_checks, n_hit;
    // Widget config per case and expected {mix_dual, route_r, route_l}
    logic [31:0] rcfg [6] = '{32'h501, 32'h101, 32'h401, 32'h601, 32'h602, 32'h201};
    logic [31:0] rexp [6] = '{32'h2, 32'h0, 32'h0, 32'h6, 32'h0, 32'h0};

    codec_node_addr u_dut (.core_clk_i(clk), .rst_i(rst), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .link_clk_i(lclk),
        .link_sync_i(lsync), .link_sdo_i(lsdo), .cmd_valid_o(cmd_valid),
        .cmd_class_o(cls), .cmd_nid_o(node_identifier), .cmd_payload_o(pay),
        .rsp_valid_o(rsp_valid), .rsp_data_o(rsp), .sel_node_o(sel_node),
        .route_l_o(rl), .route_r_o(rr), .mix_dual_o(mix));
    link_ctl_model u_link (.link_clk_o(lclk), .link_sync_o(lsync), .link_sdo_o(lsdo));

    // Clock generation
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Capture of each accepted command, mid-cycle so the pulse is settled
    always @(negedge clk) begin
        if (cmd_valid === 1'b1) begin
            n_hit++;
            cap_id = {22'h0, rsp_valid, cls, node_identifier};
            cap_pay = pay;
            cap_rsp = rsp;
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One APB transfer; held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 50) begin
            n_errors++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd & m, e);
    endtask

    function automatic logic [31:0] w(input logic [3:0] c, input logic [6:0] n,
                                      input logic [19:0] p);
        return {c, 1'b0, n, p};
    endfunction

    // Send a word and check hit count, class, node id and answer
    task automatic lcmd(input logic [31:0] word, input logic hit, input logic [31:0] id,
                        input logic [31:0] r);
        int n0;
        int i;
        n0 = n_hit;
        u_link.send(word);
        for (i = 0; i < 20 && n_hit == n0; i++) @(posedge clk);
        check(32'(n_hit - n0), {31'h0, hit});
        if (hit) begin
            check(cap_id, id);
            check(cap_rsp, r);
        end
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        n_errors = 0;
        num_checks = 0;
        n_hit = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rdc(CTRL_OFF, 32'hffffffff, 32'h0);
        rdc(TOPO_OFF, 32'hffffffff, 32'h02020101);
        rdc(WCFG_OFF, 32'hffffffff, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        check({31'h0, err}, 32'h1);
        $display("test reset_regs done");
        lcmd(w(4'h0, 7'd0, 20'h0), 1'b0, 32'h0, 32'h0);
        wr(WCFG_OFF, 32'h101);
        wr(CTRL_OFF, 32'h15);
        lcmd(w(4'h5, 7'd0, 20'hf0004), 1'b1, {23'h1, NODE_ROOT, 7'd0}, 32'h00010001);
        lcmd(w(4'hf, 7'd1, 20'h12345), 1'b1, {23'h1, NODE_FG, 7'd1}, 32'h00020002);
        lcmd(w(4'hf, 7'd0, 20'h0), 1'b1, {23'h1, NODE_ROOT, 7'd0}, 32'h00010001);
        lcmd(w(4'h5, 7'd3, 20'hfffff), 1'b1, {23'h1, NODE_WIDGET, 7'd3}, 32'h101);
        check({12'h0, cap_pay}, 32'h000fffff);
        lcmd(w(4'h3, 7'd2, 20'h0), 1'b0, 32'h0, 32'h0);
        lcmd(w(4'h5, 7'd4, 20'h0), 1'b0, 32'h0, 32'h0);
        lcmd(w(4'h5, 7'd2, 20'h0) | 32'h0800_0000, 1'b0, 32'h0, 32'h0);
        rdc(STAT_OFF, 32'h400, 32'h400);
        wr(STAT_OFF, 32'h700);
        rdc(STAT_OFF, 32'h700, 32'h0);
        $display("test link_cmds done");
        wr(WCFG_OFF, 32'h3);
        wr(PTR_OFF, 32'h0);
        wr(LDATA_OFF, 32'h3);
        wr(LDATA_OFF, 32'h2);
        wr(LDATA_OFF, 32'h83);
        rdc(STAT_OFF, 32'h700, 32'h0);
        wr(PTR_OFF, 32'h1);
        rdc(LDATA_OFF, 32'hffff, 32'h2);
        wr(SEL_OFF, 32'h1);
        rdc(SEL_OFF, 32'h7f, 32'h1);
        check({17'h0, sel_node}, 32'h2);
        wr(PTR_OFF, 32'h0);
        wr(LDATA_OFF, 32'h82);
        rdc(STAT_OFF, 32'h100, 32'h100);
        wr(STAT_OFF, 32'h700);
        wr(PTR_OFF, 32'h0);
        wr(LDATA_OFF, 32'h2);
        wr(LDATA_OFF, 32'h83);
        wr(LDATA_OFF, 32'h82);
        rdc(STAT_OFF, 32'h100, 32'h100);
        wr(STAT_OFF, 32'h700);
        wr(PTR_OFF, 32'h0);
        wr(LDATA_OFF, 32'h10);
        rdc(STAT_OFF, 32'h200, 32'h200);
        wr(WCFG_OFF, 32'h1);
        wr(SEL_OFF, 32'h1);
        rdc(SEL_OFF, 32'h7f, 32'h0);
        $display("test source_list done");
        // Stereo/mono pairings, mixer exception and its near miss
        foreach (rcfg[k]) begin
            wr(WCFG_OFF, rcfg[k]);
            rdc(ROUTE_OFF, 32'h7, rexp[k]);
            check({29'h0, mix, rr, rl}, rexp[k]);
        end
        $display("test routing done");
        stop_test();
    end
endmodule // codec_node_addr_tb
`default_nettype wire
